// file: hdl/replay_ctrl_pkg.sv
package replay_ctrl_pkg;
  // register byte addresses
  localparam logic [12:0] ADDR_UNIT0_STATUS = 13'h0cf0;
  localparam logic [12:0] ADDR_UNIT1_STATUS = 13'h0cf4;
  localparam logic [12:0] ADDR_PTR0_FORMAT = 13'h0d00;
  localparam logic [12:0] ADDR_SMALL_FORMAT = 13'h0d10;
  localparam logic [12:0] ADDR_PTR1_FORMAT = 13'h1d00;
  localparam int ADDR_W = 13;
  // status field positions
  localparam int BIT_PENDING = 7;
  localparam int BIT_TRIG_SEL = 6;
  localparam int BIT_ACTIVE = 0;
  // format field positions and codes
  localparam int FMT_SIZE_LO = 4;
  localparam int FMT_SIZE_HI = 6;
  localparam logic [2:0] SIZE_OFF = 3'h0;
  localparam logic [2:0] SIZE_1BPP = 3'h1;
  localparam logic [2:0] SIZE_16BPP = 3'h5;
  localparam logic [2:0] FMT_SIZE_RESET = 3'h0;
  localparam logic TRIG_SEL_RESET = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NUM_UNITS = 2;

  typedef enum logic [1:0]
  {
    UNIT_IDLE = 2'b00,
    UNIT_ARMED = 2'b01,
    UNIT_ACTIVE = 2'b10
  } unit_state_e;
endpackage

// file: hdl/deferred_parameter_replay_control.sv
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module deferred_parameter_replay_control
  import replay_ctrl_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // blanking from display timing, asynchronous levels
  input wire logic vertical_blank_interval_disp0,
  input wire logic vertical_blank_interval_disp1,
  // replay engine: start pulse per unit, done pulse per unit
  output logic [NUM_UNITS-1:0] replay_start,
  input wire logic [NUM_UNITS-1:0] replay_done,
  // unit status for the parameter path
  output logic [NUM_UNITS-1:0] replay_active,
  // channel pixel sizes, 0 means disabled
  output logic [2:0] pointer_overlay0_size,
  output logic [2:0] pointer_overlay1_size,
  output logic [2:0] small_overlay_size
);

  typedef struct packed
  {
    logic [1:0] vb0_sync;
    logic [1:0] vb1_sync;
    logic [1:0] vb_last;
    unit_state_e [NUM_UNITS-1:0] unit;
    logic [NUM_UNITS-1:0] pending;
    logic [NUM_UNITS-1:0] trig_sel;
    logic [NUM_UNITS-1:0] start;
    logic [2:0] ptr0_size;
    logic [2:0] ptr1_size;
    logic [2:0] small_size;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s cur_ff;
  state_s nxt_cur;

  logic [1:0] vb_rise;
  logic do_write;
  logic do_read;
  logic [NUM_UNITS-1:0] wr_unit;
  logic [NUM_UNITS-1:0] rd_unit;
  logic [ADDR_W-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [NUM_UNITS-1:0] edge_hit;
  logic [NUM_UNITS-1:0] unit0_clear;

  // per-unit trigger selection and ordering between the units
  for (genvar g = 0; g < NUM_UNITS; g++)
  begin : g_unit
    assign edge_hit[g] = cur_ff.trig_sel[g] ? vb_rise[1] : vb_rise[0];
    assign unit0_clear[g] = (g == 0) || (cur_ff.unit[0] == UNIT_IDLE);
  end

  assign s_axi_awready = !cur_ff.aw_held && !cur_ff.bvalid;
  assign s_axi_wready = !cur_ff.w_held && !cur_ff.bvalid;
  assign s_axi_arready = !cur_ff.rvalid;
  assign s_axi_bvalid = cur_ff.bvalid;
  assign s_axi_bresp = cur_ff.bresp;
  assign s_axi_rvalid = cur_ff.rvalid;
  assign s_axi_rdata = cur_ff.rdata;
  assign s_axi_rresp = cur_ff.rresp;
  assign replay_start = cur_ff.start;
  assign pointer_overlay0_size = cur_ff.ptr0_size;
  assign pointer_overlay1_size = cur_ff.ptr1_size;
  assign small_overlay_size = cur_ff.small_size;

  // leading edges of the synchronised blanking levels
  assign vb_rise[0] = cur_ff.vb0_sync[1] && !cur_ff.vb_last[0];
  assign vb_rise[1] = cur_ff.vb1_sync[1] && !cur_ff.vb_last[1];

  // status image per unit
  function automatic logic [7:0] status_byte(input logic pend, input logic sel, input logic act);
    logic [7:0] b;
    b = 8'h00;
    b[BIT_PENDING] = pend;
    b[BIT_TRIG_SEL] = sel;
    b[BIT_ACTIVE] = act;
    return b;
  endfunction

  always_comb
  begin
    do_write = (cur_ff.aw_held || s_axi_awvalid) && (cur_ff.w_held || s_axi_wvalid) && !cur_ff.bvalid;
    do_read = s_axi_arvalid && !cur_ff.rvalid;
    // a held address or data beat takes precedence over the live channel
    wa = cur_ff.aw_held ? cur_ff.aw_addr : s_axi_awaddr;
    wd = cur_ff.w_held ? cur_ff.w_data : s_axi_wdata;
    ws = cur_ff.w_held ? cur_ff.w_strb : s_axi_wstrb;
    wr_unit = '0;
    rd_unit = '0;
    nxt_cur = cur_ff;
    nxt_cur.vb0_sync = {cur_ff.vb0_sync[0], vertical_blank_interval_disp0};
    nxt_cur.vb1_sync = {cur_ff.vb1_sync[0], vertical_blank_interval_disp1};
    nxt_cur.vb_last = {cur_ff.vb1_sync[1], cur_ff.vb0_sync[1]};
    nxt_cur.start = '0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_cur.aw_held = 1'b1;
      nxt_cur.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_cur.w_held = 1'b1;
      nxt_cur.w_data = s_axi_wdata;
      nxt_cur.w_strb = s_axi_wstrb;
    end
    if (cur_ff.bvalid && s_axi_bready)
      nxt_cur.bvalid = 1'b0;
    if (cur_ff.rvalid && s_axi_rready)
      nxt_cur.rvalid = 1'b0;

    // read path: status read clears the pending flag
    if (do_read)
    begin
      nxt_cur.rvalid = 1'b1;
      nxt_cur.rresp = RESP_OKAY;
      nxt_cur.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        ADDR_UNIT0_STATUS:
        begin
          nxt_cur.rdata[7:0] = status_byte(cur_ff.pending[0], cur_ff.trig_sel[0],
            cur_ff.unit[0] == UNIT_ACTIVE);
          rd_unit[0] = 1'b1;
        end
        ADDR_UNIT1_STATUS:
        begin
          nxt_cur.rdata[7:0] = status_byte(cur_ff.pending[1], cur_ff.trig_sel[1],
            cur_ff.unit[1] == UNIT_ACTIVE);
          rd_unit[1] = 1'b1;
        end
        ADDR_PTR0_FORMAT: nxt_cur.rdata[FMT_SIZE_HI:FMT_SIZE_LO] = cur_ff.ptr0_size;
        ADDR_SMALL_FORMAT: nxt_cur.rdata[FMT_SIZE_HI:FMT_SIZE_LO] = cur_ff.small_size;
        ADDR_PTR1_FORMAT: nxt_cur.rdata[FMT_SIZE_HI:FMT_SIZE_LO] = cur_ff.ptr1_size;
        default: nxt_cur.rresp = RESP_SLVERR;
      endcase
    end

    // write path
    if (do_write)
    begin
      nxt_cur.aw_held = 1'b0;
      nxt_cur.w_held = 1'b0;
      nxt_cur.bvalid = 1'b1;
      nxt_cur.bresp = RESP_OKAY;
      case (wa)
        ADDR_UNIT0_STATUS:
          if (ws[0])
          begin
            nxt_cur.trig_sel[0] = wd[BIT_TRIG_SEL];
            wr_unit[0] = wd[BIT_PENDING];
          end
        ADDR_UNIT1_STATUS:
          if (ws[0])
          begin
            nxt_cur.trig_sel[1] = wd[BIT_TRIG_SEL];
            wr_unit[1] = wd[BIT_PENDING];
          end
        ADDR_PTR0_FORMAT:
          if (ws[0])
            nxt_cur.ptr0_size = wd[FMT_SIZE_HI:FMT_SIZE_LO];
        ADDR_SMALL_FORMAT:
          if (ws[0])
            nxt_cur.small_size = wd[FMT_SIZE_HI:FMT_SIZE_LO];
        ADDR_PTR1_FORMAT:
          if (ws[0])
            nxt_cur.ptr1_size = wd[FMT_SIZE_HI:FMT_SIZE_LO];
        default: nxt_cur.bresp = RESP_SLVERR;
      endcase
    end

    // replay units
    for (int u = 0; u < NUM_UNITS; u++)
    begin
      if (rd_unit[u])
        nxt_cur.pending[u] = 1'b0;
      case (cur_ff.unit[u])
        UNIT_IDLE:
          if (wr_unit[u])
          begin
            nxt_cur.unit[u] = UNIT_ARMED;
            nxt_cur.pending[u] = 1'b1;
          end
        UNIT_ARMED:
          if (edge_hit[u] && unit0_clear[u])
          begin
            nxt_cur.unit[u] = UNIT_ACTIVE;
            nxt_cur.start[u] = 1'b1;
          end
        UNIT_ACTIVE:
          if (replay_done[u])
          begin
            nxt_cur.unit[u] = UNIT_IDLE;
            nxt_cur.pending[u] = 1'b0;
          end
        default: nxt_cur.unit[u] = UNIT_IDLE;
      endcase
    end
  end

  always_comb
  begin
    for (int u = 0; u < NUM_UNITS; u++)
      replay_active[u] = (cur_ff.unit[u] == UNIT_ACTIVE);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur_ff <= '0;
      cur_ff.trig_sel <= {NUM_UNITS{TRIG_SEL_RESET}};
      cur_ff.ptr0_size <= FMT_SIZE_RESET;
      cur_ff.ptr1_size <= FMT_SIZE_RESET;
      cur_ff.small_size <= FMT_SIZE_RESET;
      for (int u = 0; u < NUM_UNITS; u++)
        cur_ff.unit[u] <= UNIT_IDLE;
    end
    else
      cur_ff <= nxt_cur;
  end

endmodule

// file: sim/replay_ctrl_props.sv
`timescale 1ns/1ps
module replay_ctrl_props
  import replay_ctrl_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // replay units
  input wire logic [NUM_UNITS-1:0] replay_start,
  input wire logic [NUM_UNITS-1:0] replay_done,
  input wire logic [NUM_UNITS-1:0] replay_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_b_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  a_start_act: assert property ((replay_start & ~replay_active) == 2'h0)
    else $error("start without active");
  a_start_pulse: assert property ((replay_start & $past(replay_start)) == 2'h0)
    else $error("start longer than one cycle");
  a_done_idle: assert property (replay_done[0] && replay_active[0] |=> !replay_active[0])
    else $error("active kept after done");
  a_act_hold: assert property (replay_active[1] && !replay_done[1] |=> replay_active[1])
    else $error("active dropped early");
  a_unit_order: assert property ($rose(replay_active[1]) |-> !$past(replay_active[0]))
    else $error("unit 1 started during unit 0");
endmodule
bind deferred_parameter_replay_control replay_ctrl_props replay_ctrl_props_i (.*);

// file: sim/timing_model.sv
`timescale 1ns/1ps
module timing_model
  import replay_ctrl_pkg::*;
(
  // bench control
  input wire logic aclk,
  input wire logic slow,
  input wire logic [1:0] vb_go,
  // replay engine
  input wire logic [NUM_UNITS-1:0] replay_start,
  output logic [NUM_UNITS-1:0] replay_done = '0,
  // blanking levels
  output logic vertical_blank_interval_disp0 = 1'h0,
  output logic vertical_blank_interval_disp1 = 1'h0
);
  int c [NUM_UNITS] = '{default: 0};
  // done follows start after a short or a long replay
  always @(posedge aclk)
  begin
    {vertical_blank_interval_disp1, vertical_blank_interval_disp0} <= vb_go;
    for (int u = 0; u < NUM_UNITS; u++)
    begin
      replay_done[u] <= c[u] == 1;
      if (replay_start[u])
        c[u] <= slow ? 40 : 2;
      else if (c[u] > 0)
        c[u] <= c[u] - 1;
    end
  end
endmodule

// file: sim/tb_deferred_parameter_replay_control.sv
`timescale 1ns/1ps
module tb_deferred_parameter_replay_control
  import replay_ctrl_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0, slow = 1'h0, s;
  logic [12:0] s_axi_awaddr = '0, s_axi_araddr = '0, sa;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, e;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic vertical_blank_interval_disp0, vertical_blank_interval_disp1;
  logic [1:0] s_axi_bresp, s_axi_rresp, replay_start, replay_done, replay_active, r, vb_go = '0;
  logic [2:0] pointer_overlay0_size, pointer_overlay1_size, small_overlay_size, cd [3] = '{3'h1, 3'h5, 3'h0};
  logic [12:0] fa [3] = '{ADDR_PTR0_FORMAT, ADDR_SMALL_FORMAT, ADDR_PTR1_FORMAT};
  int n_errors = 0, n_checks = 0, cyc = 0, u, seed = 32'hbbd671f0;
  deferred_parameter_replay_control deferred_parameter_replay_control_i (.*);
  timing_model timing_model_i (.*);
  initial forever #2 aclk = ~aclk;
  function automatic logic [31:0] st(input logic p, input logic t, input logic a);
    return {24'h0, p, t, 5'h0, a};
  endfunction
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
    n_checks++;
    if (x !== y)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] x);
    logic ah, wh, bh;
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    forever
    begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'h0;
      if (wh) s_axi_wvalid <= 1'h0;
      if (bh) break;
    end
  endtask
  task automatic rc(input logic [12:0] a, input logic [31:0] x);
    logic ah, rh;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    forever
    begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'h0;
      if (rh) break;
    end
    chk("rdata", x, d);
  endtask
  task automatic wstart(input int k);
    for (int i = 0; i < 50 && replay_start[k] !== 1'h1; i++) @(posedge aclk);
    chk("start", 1, replay_start[k]);
  endtask
  task automatic widle(input int k);
    for (int i = 0; i < 100 && replay_active[k] !== 1'h0; i++) @(posedge aclk);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rc(ADDR_UNIT0_STATUS, 0);
    rc(ADDR_UNIT1_STATUS, 0);
    rc(13'h0cf8, 0);
    chk("rresp", RESP_SLVERR, r);
    wr(13'h0cf8, 32'hff);
    chk("bresp", RESP_SLVERR, r);
    for (int i = 0; i < 9; i++)
    begin
      d = $random(seed);
      d[6:4] = cd[i / 3];
      e = {25'h0, d[6:4], 4'h0};
      wr(fa[i % 3], d);
      chk("size", e >> 4, {pointer_overlay0_size, small_overlay_size, pointer_overlay1_size} >> (6 - 3 * (i % 3)) & 3'h7);
      rc(fa[i % 3], e);
    end
    for (int k = 0; k < 4; k++)
    begin
      u = k % 2;
      s = k / 2;
      sa = u ? ADDR_UNIT1_STATUS : ADDR_UNIT0_STATUS;
      slow <= $random(seed);
      wr(sa, 32'(s) << 6);
      rc(sa, st(0, s, 0));
      wr(sa, 32'h80 | 32'(s) << 6);
      rc(sa, st(1, s, 0));
      rc(sa, st(0, s, 0));
      vb_go <= s ? 2'h1 : 2'h2;
      repeat (20) @(posedge aclk);
      chk("active", 0, replay_active);
      vb_go <= s ? 2'h2 : 2'h1;
      wstart(u);
      if (slow) rc(sa, st(0, s, 1));
      widle(u);
      vb_go <= 2'h0;
      rc(sa, st(0, s, 0));
    end
    // unit 1 starts only once the replay of unit 0 is reported complete
    slow <= 1'h1;
    wr(ADDR_UNIT0_STATUS, 32'h80);
    wr(ADDR_UNIT1_STATUS, 32'h80);
    vb_go <= 2'h1;
    wstart(0);
    repeat (20) @(posedge aclk);
    chk("unit1", 0, replay_active[1]);
    vb_go <= 2'h0;
    widle(0);
    vb_go <= 2'h1;
    wstart(1);
    widle(1);
    rc(ADDR_UNIT1_STATUS, 0);
    tally_and_finish;
  end
endmodule
